// File: tb_terminal_control_char_hold.sv
`timescale 1ns/1ps
`default_nettype none
module tb_terminal_control_char_hold;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, ser_rx_i, ser_tx_o, reader_run_o, par_dav_n_i, par_rdav_n_o;
  logic key_valid_i = 1'b0;
  logic [6:0] key_i = 7'h00;
  logic key_ctrl_i = 1'b0;
  logic key_shift_i = 1'b0;
  logic [7:0] par_data_i, last_wr;
  logic disp_we_o, cursor_blink_o, scroll_o, clear_o, speaker_o, tk;
  logic [3:0] disp_row_o, cursor_row_o;
  logic [6:0] disp_col_o, disp_char_o, cursor_col_o;
  int errors = 0;
  int tests_run = 0;
  int wr_cnt = 0;
  int beeps = 0;
  int b0;
  int scrolls = 0;
  int clears = 0;
  logic [10:0] last_pos;
  always #4 clk_i = ~clk_i;
  tcc_term_ctrl #(.BELL_CYCLES(40), .TONE_HALF(4), .BAUD_BASE_DIV(8)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .key_valid_i(key_valid_i), .key_i(key_i),
    .key_ctrl_i(key_ctrl_i), .key_shift_i(key_shift_i), .ser_rx_i(ser_rx_i),
    .ser_tx_o(ser_tx_o), .reader_run_o(reader_run_o), .par_data_i(par_data_i),
    .par_dav_n_i(par_dav_n_i), .par_rdav_n_o(par_rdav_n_o), .disp_we_o(disp_we_o),
    .disp_row_o(disp_row_o), .disp_col_o(disp_col_o), .disp_char_o(disp_char_o),
    .cursor_row_o(cursor_row_o), .cursor_col_o(cursor_col_o),
    .cursor_blink_o(cursor_blink_o), .scroll_o(scroll_o), .clear_o(clear_o),
    .speaker_o(speaker_o));
  tcc_far_end #(.BIT(128)) u_far (
    .clk_i(clk_i), .ser_o(ser_rx_i), .ser_i(ser_tx_o), .reader_run_i(reader_run_o),
    .par_data_o(par_data_i), .par_dav_n_o(par_dav_n_i), .par_rdav_n_i(par_rdav_n_o));
  always @(posedge clk_i) begin
    if (disp_we_o === 1'b1) begin
      last_wr <= {1'b0, disp_char_o};
      last_pos <= {disp_row_o, disp_col_o};
      wr_cnt <= wr_cnt + 1;
    end
    if (scroll_o === 1'b1) scrolls <= scrolls + 1;
    if (clear_o === 1'b1) clears <= clears + 1;
  end
  always @(posedge speaker_o) beeps++;
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // A key is sent on the line as well, so wait for the host to see it.
  task automatic key_tx(input logic [6:0] k, input logic c, input logic s, input logic [7:0] e);
    int c0;
    int n;
    c0 = u_far.rx_cnt;
    n = 0;
    @(posedge clk_i);
    key_valid_i <= 1'b1;
    key_i <= k;
    key_ctrl_i <= c;
    key_shift_i <= s;
    @(posedge clk_i);
    key_valid_i <= 1'b0;
    while (u_far.rx_cnt == c0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    chk("key framed", u_far.rx_cnt - c0, 1);
    chk("sent key", u_far.rx_byte, e);
    // The stop bit is still on the line; a key pressed before it ends is dropped.
    repeat (128) @(posedge clk_i);
  endtask
  // Control keys in quick succession; only the display action is looked at.
  task automatic tap(input logic [6:0] k, input int cnt);
    repeat (cnt) begin
      @(posedge clk_i);
      key_valid_i <= 1'b1;
      key_i <= k;
      key_ctrl_i <= 1'b1;
      key_shift_i <= 1'b0;
      @(posedge clk_i);
      key_valid_i <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
  endtask
  task automatic host(input logic [7:0] b);
    u_far.send_ser(b);
    repeat (8) @(posedge clk_i);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    errors++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, tcc_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", q, 32'h000000C4);
    chk("line idle", ser_tx_o, 1'b1);
    bus(1'b1, tcc_pkg::REG_CTRL, 32'h000004C4);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("reader loop", reader_run_o, 1'b1);
    $display("test registers done");
    key_tx(7'h61, 1'b0, 1'b0, 8'h41);
    chk("upper shown", last_wr, 8'h41);
    key_tx(7'h50, 1'b1, 1'b1, 8'h00);
    chk("null column", cursor_col_o, 7'h01);
    key_tx(7'h6D, 1'b1, 1'b0, 8'h0D);
    chk("return column", cursor_col_o, 7'h00);
    for (int i = 0; i < 32; i++) begin
      key_tx(7'h40 | 7'(i), 1'b1, 1'b0, 8'(i));
    end
    chk("controls unstored", wr_cnt, 1);
    chk("one feed", cursor_row_o, 4'h1);
    $display("test keyboard done");
    host(8'h58);
    chk("serial char", last_wr, 8'h58);
    chk("serial place", last_pos, {4'h1, 7'h00});
    bus(1'b0, tcc_pkg::REG_LAST, 32'h0);
    chk("last serial", q, 32'h00000058);
    host(8'h08);
    chk("back col", cursor_col_o, 7'h00);
    chk("back keeps", wr_cnt, 2);
    host(8'h01);
    chk("other code", {cursor_row_o, cursor_col_o}, {4'h1, 7'h00});
    b0 = beeps;
    host(8'h07);
    repeat (40) @(posedge clk_i);
    chk("bell tone", beeps > b0, 1'b1);
    host(8'h0A);
    chk("feed row", cursor_row_o, 4'h2);
    u_far.send_par(8'h51, tk);
    repeat (8) @(posedge clk_i);
    chk("parallel taken", tk, 1'b1);
    chk("parallel col", cursor_col_o, 7'h01);
    $display("test inputs done");
    for (int i = 0; i < 10; i++) begin
      host(8'h0A);
    end
    chk("hold blink", cursor_blink_o, 1'b1);
    chk("hold home", {cursor_row_o, cursor_col_o}, 11'h0);
    bus(1'b0, tcc_pkg::REG_STATUS, 32'h0);
    chk("hold status", q, 32'h00000001);
    host(8'h58);
    chk("hold serial", wr_cnt, 3);
    u_far.send_par(8'h52, tk);
    chk("hold handshake", tk, 1'b0);
    key_tx(7'h7A, 1'b0, 1'b0, 8'h5A);
    bus(1'b1, tcc_pkg::REG_CMD, 32'h1);
    repeat (4) @(posedge clk_i);
    chk("hold ends", cursor_blink_o, 1'b0);
    chk("page cleared", clears, 1);
    $display("test hold done");
    tap(7'h4A, 12);
    chk("hold again", cursor_blink_o, 1'b1);
    bus(1'b1, tcc_pkg::REG_CTRL, 32'h000004C5);
    repeat (2) @(posedge clk_i);
    chk("scroll frees", cursor_blink_o, 1'b0);
    tap(7'h4A, 12);
    chk("scrolled", scrolls, 1);
    chk("bottom row", cursor_row_o, 4'hB);
    bus(1'b1, tcc_pkg::REG_CTRL, 32'h000004C6);
    tap(7'h47, 1);
    chk("plot stores", last_wr, 8'h07);
    chk("plot place", last_pos, {4'hB, 7'h00});
    $display("test modes done");
    print_verdict();
  end
endmodule // tb_terminal_control_char_hold
`default_nettype wire

// File: tcc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_far_end #(
  parameter int BIT = 128
) (
  // Clock.
  input wire logic clk_i,
  // Serial pair and reader loop.
  output logic ser_o,
  input wire logic ser_i,
  input wire logic reader_run_i,
  // Tape reader on the parallel port.
  output logic [7:0] par_data_o,
  output logic par_dav_n_o,
  input wire logic par_rdav_n_i
);
  logic [7:0] rx_byte;
  int rx_cnt;
  initial begin
    ser_o = 1'b1;
    par_dav_n_o = 1'b1;
    par_data_o = 8'h00;
    rx_byte = 8'h00;
    rx_cnt = 0;
  end
  // Host frame is start, eight data bits LSB first, no parity, one stop bit.
  task automatic send_ser(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      ser_o <= f[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
  endtask
  // The reader runs only while the loop sits at mark.
  task automatic send_par(input logic [7:0] b, output logic taken);
    int n;
    taken = 1'b0;
    n = 0;
    if (reader_run_i !== 1'b1) return;
    @(posedge clk_i);
    par_data_o <= b;
    par_dav_n_o <= 1'b0;
    while (par_rdav_n_i !== 1'b0 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    taken = (par_rdav_n_i === 1'b0);
    par_dav_n_o <= 1'b1;
    // Released data lines show garbage, not the last byte.
    par_data_o <= ~b;
  endtask
  // Host receiver samples each bit in its middle.
  always begin
    @(negedge ser_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      rx_byte[i] = ser_i;
    end
    repeat (BIT) @(posedge clk_i);
    rx_cnt++;
  end
endmodule // tcc_far_end
`default_nettype wire

// File: tcc_key_enc.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_key_enc (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Key matrix event.
  input wire logic key_valid_i,
  input wire logic [6:0] key_i,
  input wire logic key_ctrl_i,
  input wire logic key_shift_i,
  // Encoded character.
  output logic valid_o,
  output logic [6:0] code_o
);
  typedef struct packed {
    logic valid;
    logic [6:0] code;
  } tcc_enc_s;
  tcc_enc_s q, d;
  logic [6:0] up;

  always_comb begin
    up = key_i;
    if (key_i >= 7'h61 && key_i <= 7'h7A) begin
      up = key_i - 7'h20;
    end
    d.valid = key_valid_i;
    d.code = q.code;
    if (key_valid_i) begin
      if (key_ctrl_i && key_shift_i) begin
        d.code = (up + 7'h10) & 7'h1F;
      end else if (key_ctrl_i) begin
        d.code = up & 7'h1F;
      end else begin
        d.code = up;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign valid_o = q.valid;
  assign code_o = q.code;

  a_null_code: assert property (@(posedge clk_i) disable iff (rst_i)
    key_valid_i && key_ctrl_i && key_shift_i && key_i == 7'h50 |=> valid_o && code_o == 7'h00)
    else $error("Control shift P did not give the null code.");
  a_upper_only: assert property (@(posedge clk_i) disable iff (rst_i)
    key_valid_i && !key_ctrl_i && key_i >= 7'h61 && key_i <= 7'h7A
    |=> code_o == $past(key_i) - 7'h20)
    else $error("Letter key gave a lower-case code.");
  a_ctrl_m_cr: assert property (@(posedge clk_i) disable iff (rst_i)
    key_valid_i && key_ctrl_i && !key_shift_i && key_i == 7'h4D |=> code_o == tcc_pkg::CH_CR)
    else $error("Control M did not give carriage return.");
endmodule // tcc_key_enc
`default_nettype wire

// File: tcc_pkg.sv
package tcc_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_LAST = 8'h0C;
  // Control register fields.
  localparam int CTRL_SCROLL = 0;
  localparam int CTRL_PLOT = 1;
  localparam int CTRL_PRESET = 2;
  localparam int CTRL_IDX = 3;
  localparam int CTRL_WLEN_LO = 6;
  localparam int CTRL_WLEN_HI = 7;
  localparam int CTRL_PAR_EN = 8;
  localparam int CTRL_PAR_EVEN = 9;
  localparam int CTRL_READER = 10;
  localparam logic [10:0] CTRL_RESET = 11'h0C4;
  // Command and status fields.
  localparam int CMD_ERASE = 0;
  localparam int CMD_PERR_CLR = 1;
  localparam int ST_HOLD = 0;
  localparam int ST_TX_BUSY = 1;
  localparam int ST_PERR = 2;
  localparam int ST_BELL = 3;
  localparam int ST_COL = 8;
  localparam int ST_ROW = 16;
  // Screen geometry and control codes.
  localparam int unsigned COLS = 80;
  localparam int unsigned ROWS = 12;
  localparam logic [6:0] CH_BEL = 7'h07;
  localparam logic [6:0] CH_BS = 7'h08;
  localparam logic [6:0] CH_LF = 7'h0A;
  localparam logic [6:0] CH_CR = 7'h0D;
  localparam logic [6:0] CH_SPACE = 7'h20;
  // Times and the cycle counts derived from them.
  localparam int unsigned RDAV_PULSE_NS = 25_000;
  localparam int unsigned RDAV_CYCLES = RDAV_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned BELL_TIME_MS = 100;
  localparam int unsigned BELL_CYCLES_DEF = BELL_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned TONE_HZ = 1000;
  localparam int unsigned TONE_HALF_DEF = CLK_HZ / (2 * TONE_HZ);
  localparam int unsigned BAUD_REF = 9600;
  localparam int unsigned BAUD_DIV_DEF = CLK_HZ / BAUD_REF;

  // 300 baud is 32 reference bit times; presets run 600 (idx 0) to 9600 (idx 4).
  function automatic logic [23:0] baud_div(input logic [23:0] base,
                                           input logic preset, input logic [2:0] idx);
    logic [2:0] i;
    i = (idx > 3'h4) ? 3'h4 : idx;
    baud_div = preset ? (base << (3'h4 - i)) : (base << 5);
  endfunction

  function automatic logic [7:0] data_mask(input logic [1:0] wlen);
    data_mask = 8'hFF >> (2'h3 - wlen);
  endfunction

  function automatic logic parity_bit(input logic [7:0] data, input logic even);
    parity_bit = even ? ^data : ~^data;
  endfunction
endpackage

// File: tcc_serial_tx.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_serial_tx (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Frame format.
  input wire logic [23:0] div_i,
  input wire logic [1:0] wlen_i,
  input wire logic par_en_i,
  input wire logic par_even_i,
  // Character request.
  input wire logic start_i,
  input wire logic [7:0] data_i,
  output logic ready_o,
  // Line, idle at mark.
  output logic tx_o
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tcc_tx_e;
  typedef struct packed {
    tcc_tx_e st;
    logic [23:0] cnt;
    logic [7:0] sh;
    logic [2:0] n;
    logic par;
    logic txd;
  } tcc_tx_s;
  tcc_tx_s q, d;
  logic last;

  always_comb begin
    d = q;
    last = (q.n == {1'b0, wlen_i} + 3'h4);
    if (q.st != TX_IDLE && q.cnt != 24'h0) begin
      d.cnt = q.cnt - 24'h1;
    end else begin
      d.cnt = div_i - 24'h1;
      case (q.st)
        TX_IDLE: begin
          if (start_i) begin
            d.sh = data_i & tcc_pkg::data_mask(wlen_i);
            d.par = tcc_pkg::parity_bit(data_i & tcc_pkg::data_mask(wlen_i), par_even_i);
            d.n = 3'h0;
            d.txd = 1'b0;
            d.st = TX_START;
          end
        end
        TX_START, TX_DATA: begin
          d.txd = q.sh[0];
          d.sh = q.sh >> 1;
          d.n = (q.st == TX_START) ? 3'h0 : q.n + 3'h1;
          d.st = TX_DATA;
          if (q.st == TX_DATA && last) begin
            d.st = par_en_i ? TX_PAR : TX_STOP;
            d.txd = par_en_i ? q.par : 1'b1;
          end
        end
        TX_PAR: begin
          d.txd = 1'b1;
          d.st = TX_STOP;
        end
        TX_STOP: d.st = TX_IDLE;
        default: d.st = TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{st: TX_IDLE, txd: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign ready_o = (q.st == TX_IDLE);
  assign tx_o = q.txd;
endmodule // tcc_serial_tx
`default_nettype wire

// File: tcc_term_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Ctrl shift P yields the null code.
// - Letter keys without ctrl give upper case.
// - Ctrl with letter yields its control code.
// - All 32 control codes reachable from keys.
// - Control codes not stored outside plot mode.
// - Four codes acted on from every source.
// - Received LF equals the line feed key.
// - Received CR equals the return key.
// - BS moves cursor left, display untouched.
// - BEL sounds a short speaker tone.
// - Full screen without scroll enters hold.
// - Hold homes the cursor and blinks it.
// - Hold ignores serial and parallel input.
// - Hold transmits keyboard characters only.
// - Scroll enable or page clear ends hold.
// - Hold withholds the parallel input handshake.
// - Reader loop mark enables, space disables.
// - Rate is 300 or one preset rate.
// - Default link is 600, 8 bits, no parity.
// - Five to eight bits, optional odd/even parity.
// - Mark is logic one, space logic zero.
// - Line feed moves down, writes nothing.
// - Return goes to column zero of line.
module tcc_term_ctrl #(
  parameter int unsigned BELL_CYCLES = tcc_pkg::BELL_CYCLES_DEF,
  parameter int unsigned TONE_HALF = tcc_pkg::TONE_HALF_DEF,
  parameter int unsigned BAUD_BASE_DIV = tcc_pkg::BAUD_DIV_DEF
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone register slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Keyboard matrix.
  input wire logic key_valid_i,
  input wire logic [6:0] key_i,
  input wire logic key_ctrl_i,
  input wire logic key_shift_i,
  // Serial link and reader loop.
  input wire logic ser_rx_i,
  output logic ser_tx_o,
  output logic reader_run_o,
  // Parallel input port.
  input wire logic [7:0] par_data_i,
  input wire logic par_dav_n_i,
  output logic par_rdav_n_o,
  // Display side.
  output logic disp_we_o,
  output logic [3:0] disp_row_o,
  output logic [6:0] disp_col_o,
  output logic [6:0] disp_char_o,
  output logic [3:0] cursor_row_o,
  output logic [6:0] cursor_col_o,
  output logic cursor_blink_o,
  output logic scroll_o,
  output logic clear_o,
  output logic speaker_o
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} tcc_rx_e;
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [10:0] ctrl;
    logic perr;
    logic [7:0] last;
    logic hold;
    logic [6:0] col;
    logic [3:0] row;
    logic we;
    logic [6:0] wcol;
    logic [3:0] wrow;
    logic [6:0] wch;
    logic scroll;
    logic clear;
    logic [23:0] bell;
    logic [19:0] tone;
    logic spk;
    logic rx_s1;
    logic rx_s2;
    tcc_rx_e rx_st;
    logic [23:0] rx_cnt;
    logic [7:0] rx_sh;
    logic [2:0] rx_n;
    logic rx_bad;
    logic ser_pend;
    logic [7:0] ser_ch;
    logic pdav_s1;
    logic pdav_s2;
    logic [7:0] pd_s1;
    logic [7:0] pd_s2;
    logic p_taken;
    logic [11:0] rdav_cnt;
    logic rdav_n;
    logic par_pend;
    logic [6:0] par_ch;
    logic tx_go;
    logic [7:0] tx_ch;
  } tcc_st_s;
  tcc_st_s q, d;

  logic kb_v;
  logic [6:0] kb_ch;
  logic tx_ready;
  logic [23:0] div;
  logic [1:0] wlen;
  logic act_v;
  logic [6:0] act_ch;
  logic [31:0] wr_word;
  logic acc;
  logic last_bit;

  tcc_key_enc u_enc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .key_valid_i(key_valid_i),
    .key_i(key_i),
    .key_ctrl_i(key_ctrl_i),
    .key_shift_i(key_shift_i),
    .valid_o(kb_v),
    .code_o(kb_ch)
  );

  assign div = tcc_pkg::baud_div(24'(BAUD_BASE_DIV), q.ctrl[tcc_pkg::CTRL_PRESET],
                                 q.ctrl[tcc_pkg::CTRL_IDX +: 3]);
  assign wlen = {q.ctrl[tcc_pkg::CTRL_WLEN_HI], q.ctrl[tcc_pkg::CTRL_WLEN_LO]};

  tcc_serial_tx u_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div_i(div),
    .wlen_i(wlen),
    .par_en_i(q.ctrl[tcc_pkg::CTRL_PAR_EN]),
    .par_even_i(q.ctrl[tcc_pkg::CTRL_PAR_EVEN]),
    .start_i(q.tx_go),
    .data_i(q.tx_ch),
    .ready_o(tx_ready),
    .tx_o(ser_tx_o)
  );

  // Keyboard wins; a pending serial or parallel character waits one turn.
  always_comb begin
    act_v = 1'b0;
    act_ch = kb_ch;
    if (!q.hold) begin
      if (kb_v) begin
        act_v = 1'b1;
      end else if (q.ser_pend) begin
        act_v = 1'b1;
        act_ch = q.ser_ch[6:0];
      end else if (q.par_pend) begin
        act_v = 1'b1;
        act_ch = q.par_ch;
      end
    end
  end

  assign acc = wb_cyc_i && wb_stb_i && !q.ack;
  assign last_bit = (q.rx_n == {1'b0, wlen} + 3'h4);

  always_comb begin
    d = q;
    d.ack = acc;
    d.we = 1'b0;
    d.scroll = 1'b0;
    d.clear = 1'b0;
    d.tx_go = 1'b0;
    wr_word = {21'h0, q.ctrl};
    for (int i = 0; i < 4; i++) begin
      if (wb_sel_i[i]) begin
        wr_word[i*8 +: 8] = wb_dat_i[i*8 +: 8];
      end
    end
    // Register access, answered one cycle after the strobe.
    if (acc) begin
      d.rdat = 32'h0;
      if (wb_we_i && wb_adr_i == tcc_pkg::REG_CTRL) begin
        d.ctrl = wr_word[10:0];
      end
      if (wb_we_i && wb_adr_i == tcc_pkg::REG_CMD && wb_sel_i[0]) begin
        if (wb_dat_i[tcc_pkg::CMD_ERASE]) begin
          d.clear = 1'b1;
          d.col = 7'h0;
          d.row = 4'h0;
        end
        if (wb_dat_i[tcc_pkg::CMD_PERR_CLR]) begin
          d.perr = 1'b0;
        end
      end
      if (!wb_we_i) begin
        case (wb_adr_i)
          tcc_pkg::REG_CTRL: d.rdat = {21'h0, q.ctrl};
          tcc_pkg::REG_STATUS: begin
            d.rdat[tcc_pkg::ST_HOLD] = q.hold;
            d.rdat[tcc_pkg::ST_TX_BUSY] = !tx_ready;
            d.rdat[tcc_pkg::ST_PERR] = q.perr;
            d.rdat[tcc_pkg::ST_BELL] = (q.bell != 24'h0);
            d.rdat[tcc_pkg::ST_COL +: 7] = q.col;
            d.rdat[tcc_pkg::ST_ROW +: 4] = q.row;
          end
          tcc_pkg::REG_LAST: d.rdat = {24'h0, q.last};
          default: d.rdat = 32'h0;
        endcase
      end
    end
    // Pin synchronisers.
    d.rx_s1 = ser_rx_i;
    d.rx_s2 = q.rx_s1;
    d.pdav_s1 = par_dav_n_i;
    d.pdav_s2 = q.pdav_s1;
    d.pd_s1 = par_data_i;
    d.pd_s2 = q.pd_s1;
    // Parallel input: no data is taken, nor handshake pulsed, during hold.
    if (q.rdav_cnt != 12'h0) begin
      d.rdav_cnt = q.rdav_cnt - 12'h1;
    end
    d.rdav_n = (d.rdav_cnt == 12'h0);
    if (q.pdav_s2) begin
      d.p_taken = 1'b0;
    end else if (!q.p_taken && !q.hold && !q.par_pend && q.rdav_cnt == 12'h0) begin
      d.p_taken = 1'b1;
      d.par_pend = 1'b1;
      d.par_ch = q.pd_s2[6:0];
      d.rdav_cnt = 12'(tcc_pkg::RDAV_CYCLES);
      d.rdav_n = 1'b0;
    end
    // Serial receiver, sampling each bit at its middle.
    if (q.rx_cnt != 24'h0) begin
      d.rx_cnt = q.rx_cnt - 24'h1;
    end else begin
      d.rx_cnt = div - 24'h1;
      case (q.rx_st)
        RX_IDLE: begin
          d.rx_cnt = 24'h0;
          if (!q.rx_s2) begin
            d.rx_cnt = div >> 1;
            d.rx_st = RX_START;
          end
        end
        RX_START: begin
          d.rx_n = 3'h0;
          d.rx_sh = 8'h0;
          d.rx_st = q.rx_s2 ? RX_IDLE : RX_DATA;
        end
        RX_DATA: begin
          d.rx_sh[q.rx_n] = q.rx_s2;
          d.rx_n = q.rx_n + 3'h1;
          if (last_bit) begin
            d.rx_st = q.ctrl[tcc_pkg::CTRL_PAR_EN] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          d.rx_bad = (q.rx_s2 != tcc_pkg::parity_bit(q.rx_sh,
                                                    q.ctrl[tcc_pkg::CTRL_PAR_EVEN]));
          d.rx_st = RX_STOP;
        end
        RX_STOP: begin
          d.rx_st = RX_IDLE;
          d.rx_cnt = 24'h0;
          d.last = q.rx_sh;
          d.ser_pend = !q.hold;
          d.ser_ch = q.rx_sh;
          d.perr = d.perr | (q.rx_bad & q.ctrl[tcc_pkg::CTRL_PAR_EN]);
          d.rx_bad = 1'b0;
        end
        default: d.rx_st = RX_IDLE;
      endcase
    end
    // Transmit path, only while the transmitter is ready: keyboard even in hold, parallel input only outside hold.
    if (kb_v && tx_ready) begin
      d.tx_go = 1'b1;
      d.tx_ch = {1'b0, kb_ch};
    end else if (q.par_pend && !kb_v && !q.hold && tx_ready) begin
      d.tx_go = 1'b1;
      d.tx_ch = {1'b0, q.par_ch};
    end
    if (!kb_v && q.ser_pend) begin
      d.ser_pend = 1'b0;
    end else if (!kb_v && !q.ser_pend && q.par_pend) begin
      d.par_pend = 1'b0;
    end
    if (q.hold) begin
      d.ser_pend = 1'b0;
      d.par_pend = 1'b0;
    end
    // Character action, common to all three sources.
    if (act_v) begin
      if (q.ctrl[tcc_pkg::CTRL_PLOT] || act_ch >= tcc_pkg::CH_SPACE) begin
        d.we = 1'b1;
        d.wcol = q.col;
        d.wrow = q.row;
        d.wch = act_ch;
        if (q.col == 7'(tcc_pkg::COLS - 1)) begin
          d.col = 7'h0;
          d.row = q.row + 4'h1;
        end else begin
          d.col = q.col + 7'h1;
        end
      end else begin
        case (act_ch)
          tcc_pkg::CH_LF: d.row = q.row + 4'h1;
          tcc_pkg::CH_CR: d.col = 7'h0;
          tcc_pkg::CH_BS: d.col = (q.col == 7'h0) ? 7'h0 : q.col - 7'h1;
          tcc_pkg::CH_BEL: d.bell = 24'(BELL_CYCLES);
          default: d.col = q.col;
        endcase
      end
      // Leaving the bottom line either scrolls or freezes the page.
      if (q.row == 4'(tcc_pkg::ROWS - 1) && d.row == 4'(tcc_pkg::ROWS)) begin
        d.row = 4'(tcc_pkg::ROWS - 1);
        if (q.ctrl[tcc_pkg::CTRL_SCROLL]) begin
          d.scroll = 1'b1;
        end else begin
          d.hold = 1'b1;
          d.row = 4'h0;
          d.col = 7'h0;
        end
      end
    end
    if (q.hold && (q.ctrl[tcc_pkg::CTRL_SCROLL] || q.clear)) begin
      d.hold = 1'b0;
    end
    // Bell tone: a square wave while the interval runs.
    if (q.bell != 24'h0
        && !(act_v && act_ch == tcc_pkg::CH_BEL && !q.ctrl[tcc_pkg::CTRL_PLOT])) begin
      d.bell = q.bell - 24'h1;
    end
    if (q.bell == 24'h0) begin
      d.spk = 1'b0;
      d.tone = 20'h0;
    end else if (q.tone == 20'(TONE_HALF - 1)) begin
      d.tone = 20'h0;
      d.spk = !q.spk;
    end else begin
      d.tone = q.tone + 20'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{ctrl: tcc_pkg::CTRL_RESET, rx_s1: 1'b1, rx_s2: 1'b1, pdav_s1: 1'b1,
             pdav_s2: 1'b1, rdav_n: 1'b1, rx_st: RX_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign reader_run_o = q.ctrl[tcc_pkg::CTRL_READER];
  assign par_rdav_n_o = q.rdav_n;
  assign disp_we_o = q.we;
  assign disp_row_o = q.wrow;
  assign disp_col_o = q.wcol;
  assign disp_char_o = q.wch;
  assign cursor_row_o = q.row;
  assign cursor_col_o = q.col;
  assign cursor_blink_o = q.hold;
  assign scroll_o = q.scroll;
  assign clear_o = q.clear;
  assign speaker_o = q.spk;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_hold_entry: assert property (
    act_v && act_ch == tcc_pkg::CH_LF && !q.ctrl[tcc_pkg::CTRL_PLOT] && !q.hold
    && !q.ctrl[tcc_pkg::CTRL_SCROLL] && q.row == 4'(tcc_pkg::ROWS - 1)
    |=> q.hold && cursor_blink_o && cursor_row_o == 4'h0 && cursor_col_o == 7'h0)
    else $error("Full screen without scroll did not enter hold.");
  a_hold_quiet: assert property (q.hold |=> !disp_we_o)
    else $error("Display written while holding.");
  a_hold_no_hs: assert property (q.hold && par_rdav_n_o |=> par_rdav_n_o)
    else $error("Parallel handshake pulsed while holding.");
  a_hold_release: assert property (q.hold && q.ctrl[tcc_pkg::CTRL_SCROLL] |=> !q.hold)
    else $error("Hold not released by scroll enable.");
  a_back_space: assert property (
    act_v && act_ch == tcc_pkg::CH_BS && !q.ctrl[tcc_pkg::CTRL_PLOT] && q.col != 7'h0
    |=> cursor_col_o == $past(q.col) - 7'h1 && !disp_we_o)
    else $error("Back space did not step left cleanly.");
  a_return_home: assert property (
    act_v && act_ch == tcc_pkg::CH_CR && !q.ctrl[tcc_pkg::CTRL_PLOT]
    |=> cursor_col_o == 7'h0 && !disp_we_o)
    else $error("Return did not go to column zero.");
  a_lf_down: assert property (
    act_v && act_ch == tcc_pkg::CH_LF && !q.ctrl[tcc_pkg::CTRL_PLOT] && q.row < 4'h5
    |=> cursor_row_o == $past(q.row) + 4'h1 && !disp_we_o)
    else $error("Line feed did not move down one line.");
  a_bell_start: assert property (
    act_v && act_ch == tcc_pkg::CH_BEL && !q.ctrl[tcc_pkg::CTRL_PLOT]
    |=> q.bell == 24'(BELL_CYCLES))
    else $error("Bell interval not started in full.");
  a_ctrl_unstored: assert property (
    act_v && act_ch < tcc_pkg::CH_SPACE && !q.ctrl[tcc_pkg::CTRL_PLOT] |=> !disp_we_o)
    else $error("Control code stored outside plot mode.");
  a_wb_ack: assert property (acc |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus answer not a single cycle after the strobe.");
endmodule // tcc_term_ctrl
`default_nettype wire
